// ==== inc/bbc_conv_if.sv ====
// Handshake between the channel scheduler and the shared converter.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ns
interface bbc_conv_if;
    import bbc_pkg::*;
    logic              start;
    logic              mode_bin;
    logic [DATA_W-1:0] operand;
    logic              busy;
    logic              done;
    logic              bad_digit;
    logic [DATA_W-1:0] result;

    modport sched (
        output start, mode_bin, operand,
        input  busy, done, bad_digit, result
    );
    modport conv (
        input  start, mode_bin, operand,
        output busy, done, bad_digit, result
    );
endinterface

// ==== inc/bbc_pkg.sv ====
// Constants and types shared by the BCD/binary converter files.
// Assumes one 100 MHz clock and an active-low asynchronous reset.
package bbc_pkg;

    localparam int DATA_W   = 32;
    localparam int SIGN_BIT = 31;
    localparam int DIGITS   = 7;
    localparam int DIG_W    = 28;
    localparam int MAG_W    = 24;

    localparam logic [4:0] BIN_STEPS = 5'h18;
    localparam logic [4:0] BCD_STEPS = 5'h07;

    localparam logic signed [31:0] BCD_MAX = 32'sh0098967F;
    localparam logic signed [31:0] BCD_MIN = 32'shFF676981;
    localparam logic signed [31:0] SAT_POS = 32'sh09999999;
    localparam logic signed [31:0] SAT_NEG = 32'shF6666667;
    localparam logic [3:0]         DIG_TOP = 4'h9;

    // Processing cycle: one scan of all channels per period.
    localparam int CLK_PERIOD_NS   = 10;
    localparam int PROC_CYCLE_NS   = 10240;
    localparam int PROC_CYCLE_CLKS = PROC_CYCLE_NS / CLK_PERIOD_NS;

    localparam logic MODE_BCD = 1'b0;
    localparam logic MODE_BIN = 1'b1;

    typedef enum logic [1:0] {
        CS_IDLE = 2'h0,
        CS_RUN  = 2'h1,
        CS_DONE = 2'h3
    } bbc_core_st_e;

    typedef enum logic [1:0] {
        SS_IDLE = 2'h0,
        SS_LOAD = 2'h1,
        SS_WAIT = 2'h3
    } bbc_scan_st_e;

endpackage

// ==== rtl/bbc_converter.sv ====
// Bank of BCD/binary converters sharing one sequential converter.
// Assumes all inputs are synchronous to i_clk and that the
// configuration strobes are single-cycle pulses.
`timescale 1ns/1ns
module bbc_converter
    import bbc_pkg::*;
#(
    parameter int NUM_CH     = 32,
    parameter int CYCLE_CLKS = PROC_CYCLE_CLKS
) (
    input  wire logic                           i_clk,
    input  wire logic                           i_rst_n,
    input  wire logic [NUM_CH-1:0]              i_en,
    input  wire logic [NUM_CH-1:0][DATA_W-1:0]  i_value_in,
    input  wire logic                           i_cfg_we,
    input  wire logic [$clog2(NUM_CH)-1:0]      i_cfg_ch,
    input  wire logic                           i_cfg_mode,
    input  wire logic                           i_cfg_dflt,
    output logic      [NUM_CH-1:0][DATA_W-1:0]  o_result_out,
    output logic      [NUM_CH-1:0]              o_bad_digit,
    output logic      [NUM_CH-1:0]              o_mode_bin,
    output logic                                o_cycle_done
);

    localparam int CH_W  = $clog2(NUM_CH);
    localparam int DIV_W = $clog2(CYCLE_CLKS);
    localparam logic [CH_W-1:0]  CH_LAST  = CH_W'(NUM_CH - 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CYCLE_CLKS - 1);

    bbc_conv_if cif ();

    ////////////////////////////////////////////////////////////////
    // Processing-cycle divider.

    logic [DIV_W-1:0] div_ff, nxt_div;
    logic             tick;

    always_comb begin
        tick = (div_ff == DIV_LAST);
        if (tick) begin
            nxt_div = '0;
        end else begin
            nxt_div = div_ff + DIV_W'(1);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_ff <= '0;
        end else begin
            div_ff <= nxt_div;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Mode settings. Defaults win over a write in the same cycle.

    logic [NUM_CH-1:0] mode_ff, nxt_mode;

    always_comb begin
        nxt_mode = mode_ff;
        if (i_cfg_dflt) begin
            nxt_mode = {NUM_CH{MODE_BCD}};
        end else if (i_cfg_we) begin
            nxt_mode[i_cfg_ch] = i_cfg_mode;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_ff <= '0;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    assign o_mode_bin = mode_ff;

    ////////////////////////////////////////////////////////////////
    // Channel scan. A tick that arrives mid-scan is dropped, so the
    // cycle must be long enough for all channels in binary mode.

    bbc_scan_st_e    st_ff, nxt_st;
    logic [CH_W-1:0] ch_ff, nxt_ch;
    logic            cdone_ff, nxt_cdone;
    logic            ch_en;
    logic            last_ch;

    always_comb begin
        nxt_st    = st_ff;
        nxt_ch    = ch_ff;
        nxt_cdone = 1'b0;
        ch_en     = i_en[ch_ff];
        last_ch   = (ch_ff == CH_LAST);
        cif.start    = 1'b0;
        cif.mode_bin = mode_ff[ch_ff];
        cif.operand  = i_value_in[ch_ff];
        case (st_ff)
            SS_IDLE: begin
                if (tick) begin
                    nxt_ch = '0;
                    nxt_st = SS_LOAD;
                end
            end
            SS_LOAD: begin
                if (ch_en && !cif.busy) begin
                    cif.start = 1'b1;
                    nxt_st    = SS_WAIT;
                end else if (!ch_en) begin
                    // Disabled channels are skipped at once.
                    if (last_ch) begin
                        nxt_st    = SS_IDLE;
                        nxt_cdone = 1'b1;
                    end else begin
                        nxt_ch = ch_ff + CH_W'(1);
                    end
                end
            end
            SS_WAIT: begin
                if (cif.done) begin
                    if (last_ch) begin
                        nxt_st    = SS_IDLE;
                        nxt_cdone = 1'b1;
                    end else begin
                        nxt_ch = ch_ff + CH_W'(1);
                        nxt_st = SS_LOAD;
                    end
                end
            end
            default: begin
                nxt_st = SS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_ff    <= SS_IDLE;
            ch_ff    <= '0;
            cdone_ff <= 1'b0;
        end else begin
            st_ff    <= nxt_st;
            ch_ff    <= nxt_ch;
            cdone_ff <= nxt_cdone;
        end
    end

    assign o_cycle_done = cdone_ff;

    bbc_core u_core (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .cif     (cif.conv)
    );

    ////////////////////////////////////////////////////////////////
    // Per-channel result holding. A result whose channel was
    // disabled during conversion is thrown away, not stored.

    logic store;

    assign store = (st_ff == SS_WAIT) && cif.done;

    for (genvar k = 0; k < NUM_CH; k++) begin : g_ch
        logic [DATA_W-1:0] res_ff, nxt_res;
        logic              bad_ff, nxt_bad;

        always_comb begin
            nxt_res = res_ff;
            nxt_bad = bad_ff;
            if (!i_en[k]) begin
                nxt_res = '0;
                nxt_bad = 1'b0;
            end else if (store && ch_ff == CH_W'(k)) begin
                nxt_res = cif.result;
                nxt_bad = cif.bad_digit;
            end
        end

        always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                res_ff <= '0;
                bad_ff <= 1'b0;
            end else begin
                res_ff <= nxt_res;
                bad_ff <= nxt_bad;
            end
        end

        assign o_result_out[k] = res_ff;
        assign o_bad_digit[k]  = bad_ff;

        a_off_is_zero: assert property (@(posedge i_clk)
            disable iff (!i_rst_n)
            !i_en[k] |=> o_result_out[k] == '0 && !o_bad_digit[k])
            else $error("Disabled channel result not zero.");

        // Between its own stores an enabled channel must not drift.
        a_result_held: assert property (@(posedge i_clk)
            disable iff (!i_rst_n)
            i_en[k] && !(store && ch_ff == CH_W'(k))
            |=> $stable(o_result_out[k]))
            else $error("Enabled channel result changed without a store.");
    end

    ////////////////////////////////////////////////////////////////

    a_dflt_mode_bcd: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        i_cfg_dflt |=> o_mode_bin == '0)
        else $error("Defaults did not select BCD mode.");

    a_mode_routed_in: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        cif.start |-> cif.mode_bin == mode_ff[ch_ff]
        && cif.operand == i_value_in[ch_ff])
        else $error("Converter got wrong channel mode or data.");

    a_scan_begins: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        tick && st_ff == SS_IDLE |=> st_ff == SS_LOAD
        && ch_ff == '0)
        else $error("Processing cycle did not start a scan.");

    a_result_stored: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        store && i_en[ch_ff] |=>
        o_result_out[$past(ch_ff)] == $past(cif.result))
        else $error("Converted value not stored to its channel.");

    a_scan_advances: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        store && !last_ch |=> ch_ff == $past(ch_ff) + CH_W'(1)
        && st_ff == SS_LOAD)
        else $error("Scan did not move to the next channel.");

    ////////////////////////////////////////////////////////////////
    // Configuration, scan sequencing and digit-flag storage checks.

    a_cfg_write_lands: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        i_cfg_we && !i_cfg_dflt
        |=> o_mode_bin[$past(i_cfg_ch)] == $past(i_cfg_mode))
        else $error("Mode write did not reach its channel.");

    a_mode_held: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        !i_cfg_we && !i_cfg_dflt |=> $stable(o_mode_bin))
        else $error("Mode changed without a write or default.");

    a_start_when_idle: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        cif.start |-> !cif.busy && st_ff == SS_LOAD && i_en[ch_ff])
        else $error("Converter started while busy or disabled.");

    a_skip_disabled: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        st_ff == SS_LOAD && !ch_en && !last_ch
        |=> st_ff == SS_LOAD && ch_ff == $past(ch_ff) + CH_W'(1))
        else $error("Disabled channel was not skipped.");

    a_scan_waits: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        st_ff == SS_WAIT && !cif.done
        |=> st_ff == SS_WAIT && $stable(ch_ff))
        else $error("Scan left a channel before its result.");

    a_done_ends_scan: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        o_cycle_done |-> st_ff == SS_IDLE && ch_ff == CH_LAST)
        else $error("Scan end flagged before the last channel.");

    a_bad_follows_core: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        store && i_en[ch_ff] |=>
        o_bad_digit[$past(ch_ff)] == $past(cif.bad_digit))
        else $error("Digit flag not stored to its channel.");

endmodule

// ==== rtl/bbc_core.sv ====
// Sequential converter shared by all channels, one value at a time.
// Assumes start is a one-cycle pulse given only while busy is low.
`timescale 1ns/1ns
module bbc_core
    import bbc_pkg::*;
(
    input  wire logic  i_clk,
    input  wire logic  i_rst_n,
    bbc_conv_if.conv   cif
);

    bbc_core_st_e     state_ff, nxt_state;
    logic [4:0]       cnt_ff, nxt_cnt;
    logic [DIG_W-1:0] work_ff, nxt_work;
    logic [MAG_W-1:0] num_ff, nxt_num;
    logic             neg_ff, nxt_neg;
    logic             bin_ff, nxt_bin;
    logic             bad_ff, nxt_bad;
    logic [31:0]      res_ff, nxt_res;
    logic [31:0]      mag;
    logic [MAG_W-1:0] prod;
    logic [3:0]       dig;
    logic [DIG_W-1:0] dab;
    logic [4:0]       lat_ff, nxt_lat;

    // Add three to every nibble of five or more before a shift.
    function automatic logic [DIG_W-1:0] dabble(
        input logic [DIG_W-1:0] w);
        logic [DIG_W-1:0] r;
        r = w;
        for (int i = 0; i < DIGITS; i++) begin
            if (r[4*i +: 4] > 4'h4) begin
                r[4*i +: 4] = r[4*i +: 4] + 4'h3;
            end
        end
        return r;
    endfunction

    function automatic logic digits_ok(input logic [DIG_W-1:0] w);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < DIGITS; i++) begin
            if (w[4*i +: 4] > DIG_TOP) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    ////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_work  = work_ff;
        nxt_num   = num_ff;
        nxt_neg   = neg_ff;
        nxt_bin   = bin_ff;
        nxt_bad   = bad_ff;
        nxt_res   = res_ff;
        mag  = cif.operand[31] ? 32'(-cif.operand) : cif.operand;
        prod = num_ff * 24'h00000A;
        dig  = work_ff[DIG_W-1 -: 4];
        dab  = dabble(work_ff);
        case (state_ff)
            CS_IDLE: begin
                if (cif.start) begin
                    nxt_bin = cif.mode_bin;
                    nxt_bad = 1'b0;
                    nxt_neg = cif.operand[SIGN_BIT];
                    if (cif.mode_bin == MODE_BCD) begin
                        nxt_work  = cif.operand[DIG_W-1:0];
                        nxt_num   = '0;
                        nxt_cnt   = BCD_STEPS;
                        nxt_state = CS_RUN;
                    end else if ($signed(cif.operand) > BCD_MAX) begin
                        nxt_res   = SAT_POS;
                        nxt_state = CS_DONE;
                    end else if ($signed(cif.operand) < BCD_MIN) begin
                        nxt_res   = SAT_NEG;
                        nxt_state = CS_DONE;
                    end else begin
                        nxt_num   = mag[MAG_W-1:0];
                        nxt_work  = '0;
                        nxt_cnt   = BIN_STEPS;
                        nxt_state = CS_RUN;
                    end
                end
            end
            CS_RUN: begin
                nxt_cnt = cnt_ff - 5'h01;
                if (bin_ff) begin
                    // Double dabble: magnitude bits enter from the top.
                    nxt_work = {dab[DIG_W-2:0], num_ff[MAG_W-1]};
                    nxt_num  = {num_ff[MAG_W-2:0], 1'b0};
                end else begin
                    // Illegal digit codes are clamped and flagged.
                    if (dig > DIG_TOP) begin
                        nxt_bad = 1'b1;
                        dig     = DIG_TOP;
                    end
                    nxt_num  = prod + {20'h00000, dig};
                    nxt_work = {work_ff[DIG_W-5:0], 4'h0};
                end
                if (cnt_ff == 5'h01) begin
                    nxt_state = CS_DONE;
                    if (bin_ff) begin
                        nxt_res = {neg_ff, 3'h0, nxt_work};
                    end else if (neg_ff) begin
                        nxt_res = 32'(-{8'h00, nxt_num});
                    end else begin
                        nxt_res = {8'h00, nxt_num};
                    end
                end
            end
            CS_DONE: begin
                nxt_state = CS_IDLE;
            end
            default: begin
                nxt_state = CS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_ff <= CS_IDLE;
            cnt_ff   <= 5'h00;
            work_ff  <= '0;
            num_ff   <= '0;
            neg_ff   <= 1'b0;
            bin_ff   <= 1'b0;
            bad_ff   <= 1'b0;
            res_ff   <= 32'h00000000;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            work_ff  <= nxt_work;
            num_ff   <= nxt_num;
            neg_ff   <= nxt_neg;
            bin_ff   <= nxt_bin;
            bad_ff   <= nxt_bad;
            res_ff   <= nxt_res;
        end
    end

    assign cif.busy      = (state_ff != CS_IDLE);
    assign cif.done      = (state_ff == CS_DONE);
    assign cif.result    = res_ff;
    assign cif.bad_digit = bad_ff;

    // Cycles since the last start with done still low. The latency
    // check reads this count rather than unrolling a long repetition.
    always_comb begin
        nxt_lat = lat_ff;
        if (cif.start && !cif.busy) begin
            nxt_lat = 5'h01;
        end else if (cif.done) begin
            nxt_lat = 5'h00;
        end else if (lat_ff != 5'h1F) begin
            nxt_lat = lat_ff + 5'h01;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lat_ff <= 5'h00;
        end else begin
            lat_ff <= nxt_lat;
        end
    end

    ////////////////////////////////////////////////////////////////
    a_sat_pos_out: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        cif.start && !cif.busy && cif.mode_bin
        && $signed(cif.operand) > BCD_MAX
        |=> cif.done && cif.result == SAT_POS)
        else $error("Positive overflow not saturated.");

    a_sat_neg_out: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        cif.start && !cif.busy && cif.mode_bin
        && $signed(cif.operand) < BCD_MIN
        |=> cif.done && cif.result == SAT_NEG)
        else $error("Negative overflow not saturated.");

    a_bin_latency_ok: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        cif.start && !cif.busy && cif.mode_bin
        && $signed(cif.operand) <= BCD_MAX
        && $signed(cif.operand) >= BCD_MIN
        |-> ##25 (cif.done && lat_ff == BIN_STEPS + 5'h01))
        else $error("Binary to BCD did not finish in 25 cycles.");

    a_bcd_latency_ok: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        cif.start && !cif.busy && !cif.mode_bin
        |=> !cif.done [*7] ##1 cif.done)
        else $error("BCD to binary did not finish in 8 cycles.");

    a_digit_range_ok: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        cif.done && bin_ff |-> digits_ok(cif.result[DIG_W-1:0]))
        else $error("BCD result holds an illegal digit.");

    a_bcd_value_range: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        cif.done && !bin_ff |-> $signed(cif.result) <= BCD_MAX
        && $signed(cif.result) >= BCD_MIN)
        else $error("Binary result outside seven digits.");

    a_bcd_sign_used: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        cif.done && !bin_ff && cif.result != 32'h00000000
        |-> cif.result[31] == neg_ff)
        else $error("Binary result sign differs from BCD sign.");

endmodule

// ==== tb/bbc_converter_tb.sv ====
// Self-checking bench for the converter bank with two channels.
// Assumes the design package and the control model are compiled first.
`timescale 1ns/1ns
module bbc_converter_tb;
    import bbc_pkg::*;
    localparam int NCH = 2;
    localparam int CYC = 64;
    logic                         i_clk;
    logic                         i_rst_n;
    logic [NCH-1:0]               en;
    logic [NCH-1:0][DATA_W-1:0]   vin;
    logic                         cfg_we;
    logic [0:0]                   cfg_ch;
    logic                         cfg_mode;
    logic                         cfg_dflt;
    logic [NCH-1:0][DATA_W-1:0]   res;
    logic [NCH-1:0]               bad;
    logic [NCH-1:0]               mode_bin;
    logic                         cycle_done;
    logic [NCH-1:0]               mode_exp;
    logic [NCH-1:0][DATA_W-1:0]   v;
    logic [DATA_W-1:0]            exp_q[$];
    logic                         exp_bad_q[$];
    int                           fails = 0;
    int                           checked = 0;
    int                           seed = 60241;
    localparam logic [DATA_W-1:0] BCDV[6] = '{32'h09999999, 32'h89999999,
        32'h0000000A, 32'h80000000, 32'h70000001, 32'h0F3A5BC1};
    localparam logic [DATA_W-1:0] BINV[6] = '{32'h0098967F, 32'h00989680,
        32'hFF676981, 32'hFF676980, 32'h7FFFFFFF, 32'h80000000};

    bbc_converter #(.NUM_CH(NCH), .CYCLE_CLKS(CYC)) u_bbc_converter (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_en(en), .i_value_in(vin),
        .i_cfg_we(cfg_we), .i_cfg_ch(cfg_ch), .i_cfg_mode(cfg_mode),
        .i_cfg_dflt(cfg_dflt), .o_result_out(res), .o_bad_digit(bad),
        .o_mode_bin(mode_bin), .o_cycle_done(cycle_done));

    bbc_ctrl_model #(.NUM_CH(NCH)) u_bbc_ctrl_model (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_result_out(res),
        .i_cycle_done(cycle_done), .o_en(en), .o_value_in(vin));

    initial i_clk = 1'b0;
    always #5 i_clk = ~i_clk;

    ////////////////////////////////////////////////////////////////////
    // Reference conversions, written independently of the design.
    function automatic logic [DATA_W-1:0] bcd_to_bin(
            input logic [DATA_W-1:0] w, output logic b);
        logic [3:0] d;
        int         mag;
        mag = 0;
        b = 1'b0;
        for (int i = DIGITS - 1; i >= 0; i--) begin
            d = w[4*i +: 4];
            if (d > 4'h9) begin
                b = 1'b1;
                d = 4'h9;
            end
            mag = mag * 10 + d;
        end
        return w[SIGN_BIT] ? -mag : mag;
    endfunction

    function automatic logic [DATA_W-1:0] bin_to_bcd(
            input logic signed [DATA_W-1:0] x);
        logic [DATA_W-1:0] r;
        int                mag;
        if (x > 32'sh0098967F) return 32'h09999999;
        if (x < 32'shFF676981) return 32'hF6666667;
        r = '0;
        mag = (x < 0) ? -x : x;
        for (int i = 0; i < DIGITS; i++) begin
            r[4*i +: 4] = 4'(mag % 10);
            mag = mag / 10;
        end
        r[SIGN_BIT] = (x < 0);
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [DATA_W-1:0] e,
                         input logic [DATA_W-1:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic complete_run();
        $display("Comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        do begin
            @(negedge i_clk);
            n++;
        end while (cycle_done !== 1'b1 && n < 4 * CYC);
        check("cycle_done", 32'h00000001, {31'h0, cycle_done});
    endtask

    // The scan in flight when inputs change may mix old and new values,
    // so one scan is skipped before the expectations are queued.
    task automatic apply(input logic [NCH-1:0] e,
                         input logic [NCH-1:0][DATA_W-1:0] x);
        logic [DATA_W-1:0] r;
        logic              b;
        u_bbc_ctrl_model.set_all(e, x);
        wait_done();
        @(posedge i_clk);
        #1;
        for (int c = 0; c < NCH; c++) begin
            b = 1'b0;
            if (!e[c]) begin
                r = '0;
            end else if (mode_exp[c]) begin
                r = bin_to_bcd(x[c]);
            end else begin
                r = bcd_to_bin(x[c], b);
            end
            exp_q.push_back(r);
            exp_bad_q.push_back(b);
        end
        wait_done();
        @(posedge i_clk);
    endtask

    task automatic cfg(input logic we, input logic ch, input logic m,
                       input logic d);
        @(negedge i_clk);
        cfg_we = we;
        cfg_ch = ch;
        cfg_mode = m;
        cfg_dflt = d;
        @(negedge i_clk);
        cfg_we = 1'b0;
        cfg_dflt = 1'b0;
        if (d) begin
            mode_exp = '0;
        end else if (we) begin
            mode_exp[ch] = m;
        end
        check("mode_bin", {30'h0, mode_exp}, {30'h0, mode_bin});
    endtask

    ////////////////////////////////////////////////////////////////////
    // Each completed scan retires one note per channel, oldest first.
    always @(negedge i_clk) begin
        logic eb;
        if (cycle_done === 1'b1 && exp_q.size() >= NCH) begin
            for (int c = 0; c < NCH; c++) begin
                check("result_out", exp_q.pop_front(), res[c]);
                eb = exp_bad_q.pop_front();
                if (eb !== 1'bx) begin
                    check("bad_digit", {31'h0, eb}, {31'h0, bad[c]});
                end
            end
        end
    end

    initial begin
        repeat (40000) @(posedge i_clk);
        fails++;
        $display("MISMATCH watchdog expected end seen timeout");
        complete_run();
    end

    initial begin
        i_rst_n = 1'b0;
        cfg_we = 1'b0;
        cfg_ch = 1'b0;
        cfg_mode = 1'b0;
        cfg_dflt = 1'b0;
        mode_exp = '0;
        repeat (16) @(posedge i_clk);
        @(negedge i_clk);
        i_rst_n = 1'b1;
        check("mode_bin", 32'h00000000, {30'h0, mode_bin});
        check("result_out", 32'h00000000, res[0] | res[1]);
        cfg(1'b1, 1'b1, 1'b1, 1'b0);
        for (int i = 0; i < 6; i++) begin
            v[0] = BCDV[i];
            v[1] = BINV[i];
            apply(2'b11, v);
        end
        for (int i = 0; i < 6; i++) begin
            v[0] = bin_to_bcd($random(seed) % 32'sh00989680);
            v[1] = (i % 2) ? $random(seed) : $random(seed) % 32'sh00989680;
            apply(2'b11, v);
        end
        cfg(1'b1, 1'b0, 1'b1, 1'b0);
        cfg(1'b1, 1'b1, 1'b0, 1'b0);
        v[0] = 32'hFF676981;
        v[1] = 32'h81234567;
        apply(2'b11, v);
        apply(2'b10, v);
        cfg(1'b1, 1'b0, 1'b1, 1'b1);
        apply(2'b11, v);
        complete_run();
    end
endmodule

// ==== tb/bbc_ctrl_model.sv ====
// Model of the control logic around the converter bank: it supplies
// each channel's enable and input value and collects the results.
// Assumes the bench calls set_all and that i_clk runs throughout.
`timescale 1ns/1ns
module bbc_ctrl_model
    import bbc_pkg::*;
#(
    parameter int NUM_CH = 2
) (
    input  wire logic                          i_clk,
    input  wire logic                          i_rst_n,
    input  wire logic [NUM_CH-1:0][DATA_W-1:0] i_result_out,
    input  wire logic                          i_cycle_done,
    output logic      [NUM_CH-1:0]             o_en,
    output logic      [NUM_CH-1:0][DATA_W-1:0] o_value_in
);
    logic [NUM_CH-1:0][DATA_W-1:0] marker_ff;

    initial begin
        o_en = '0;
        o_value_in = '0;
    end

    ////////////////////////////////////////////////////////////////////
    // Values change on the falling edge so the converter never samples
    // a half-updated input.
    task automatic set_all(input logic [NUM_CH-1:0] en,
                           input logic [NUM_CH-1:0][DATA_W-1:0] v);
        @(negedge i_clk);
        o_en = en;
        o_value_in = v;
    endtask

    ////////////////////////////////////////////////////////////////////
    // Results land in marker words once a scan completes.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            marker_ff <= '0;
        end else if (i_cycle_done) begin
            marker_ff <= i_result_out;
        end
    end
endmodule
